/* File: verilog/lift_service_pkg.sv */
package lift_service_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FLASH_MAX_S = 30;
  localparam int unsigned PRESS_MIN_S = 3;
  localparam int unsigned PRESS_MAX_S = 6;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned RELEASE_DELAY_MS = 500;
  localparam int unsigned FLASH_MAX_TK = FLASH_MAX_S * 1000 / TICK_MS;
  localparam int unsigned PRESS_MIN_TK = PRESS_MIN_S * 1000 / TICK_MS;
  localparam int unsigned PRESS_MAX_TK = PRESS_MAX_S * 1000 / TICK_MS;
  localparam int unsigned BLINK_HALF_TK = BLINK_HALF_MS / TICK_MS;
  localparam int unsigned RELEASE_DELAY_TK = RELEASE_DELAY_MS / TICK_MS;
  localparam int unsigned N_ACCESS = 2;
  localparam int unsigned N_CALLS = 16;
  typedef enum logic [2:0] {PIT_IDLE, PIT_INSIDE, PIT_EXITING, PIT_OUT, PIT_FLASH, PIT_PRESS} pit_state_t;
  typedef enum logic [2:0] {DRV_IDLE, DRV_START, DRV_RUN, DRV_STOPPING, DRV_HOLD} drv_state_t;
endpackage

/* File: verilog/lift_service_mode.sv */
module lift_service_mode #(
  parameter int unsigned TICK_CYC = lift_service_pkg::TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  // service switches
  input wire logic ero_switch,
  input wire logic insp_switch,
  input wire logic insp_up,
  input wire logic insp_down,
  input wire logic safety_chain_ok,
  input wire logic bypassed_contacts_ok,
  input wire logic has_abs_encoder,
  input wire logic group_install,
  // pit exit
  input wire logic pit_insp_switch,
  input wire logic pit_stop_actuated,
  input wire logic pit_door_closed,
  input wire logic pit_key_reset,
  input wire logic [lift_service_pkg::N_ACCESS-1:0] lowest_call,
  input wire logic [lift_service_pkg::N_ACCESS-1:0] reset_access_sel,
  input wire logic unlock_confirmed,
  // calls and travel
  input wire logic [lift_service_pkg::N_CALLS-1:0] call_in,
  input wire logic travel_request,
  input wire logic travel_up,
  input wire logic travel_stop,
  // inverter
  input wire logic brake_open_signal,
  input wire logic contactor_relay,
  input wire logic inverter_fault,
  input wire logic inverter_mains_on,
  input wire logic standstill,
  output logic [lift_service_pkg::N_CALLS-1:0] calls,
  output logic normal_mode,
  output logic correction_travel,
  output logic ack_lamp,
  output logic door_lock,
  output logic drive_release,
  output logic main_contactor,
  output logic dir_up,
  output logic dir_down,
  output logic fast_speed_command,
  output logic brake_relay,
  output logic motor_contactor,
  output logic mains_contactor
);
  typedef struct packed {
    logic [31:0] div;
    logic [15:0] tk;
    logic [15:0] blink;
    logic [15:0] press;
    logic [15:0] hold;
    logic phase_on;
    lift_service_pkg::pit_state_t pit;
    lift_service_pkg::drv_state_t drv;
    logic ero_act;
    logic insp_act;
    logic toggled;
    logic blocked;
    logic need_corr;
    logic [lift_service_pkg::N_CALLS-1:0] calls;
    logic drel;
    logic up;
    logic down;
    logic fast;
    logic lock;
  } state_t;

  state_t cur;
  state_t nxt;
  logic tick;
  logic service;
  logic chain_ok;
  logic held;
  logic reset_call;
  logic reset_ok;

  assign tick = (cur.div == TICK_CYC - 1);
  assign service = cur.insp_act | cur.ero_act;
  // ero bypasses governor, buffer, limit, gear, pressure contacts
  assign chain_ok = safety_chain_ok & (cur.ero_act | bypassed_contacts_ok);
  assign held = insp_up ^ insp_down;
  assign reset_call = |(lowest_call & reset_access_sel) & ~group_install;
  // exit preconditions shared by every reset source
  assign reset_ok = ~pit_insp_switch & pit_door_closed & ~pit_stop_actuated;

  // next state
  always_comb begin
    nxt = cur;
    nxt.div = tick ? 32'h0 : cur.div + 32'h1;
    // inspection wins over emergency operation
    nxt.insp_act = insp_switch;
    nxt.ero_act = ero_switch & ~insp_switch;
    if (service && (cur.ero_act != nxt.ero_act || cur.insp_act != nxt.insp_act)) begin
      nxt.toggled = 1'b1;
    end
    // calls dropped and inputs ignored in service modes
    if (insp_switch || ero_switch) begin
      nxt.calls = '0;
    end else if (normal_mode) begin
      nxt.calls = cur.calls | call_in;
    end
    if (!cur.blocked && !service && cur.need_corr && |call_in) begin
      nxt.need_corr = 1'b0;
    end
    if (service && !nxt.ero_act && !nxt.insp_act) begin
      // leaving service mode: correction travel unless absolute encoder
      nxt.need_corr = ~has_abs_encoder;
    end
    if (tick) begin
      nxt.tk = cur.tk + 16'h1;
      // separate timer so a drive stop never stretches the pit flash window
      nxt.hold = cur.hold + 16'h1;
      nxt.blink = cur.blink + 16'h1;
      if (cur.blink == 16'(lift_service_pkg::BLINK_HALF_TK - 1)) begin
        nxt.blink = 16'h0;
        nxt.phase_on = ~cur.phase_on;
      end
    end
    // pit inspection entry and exit sequence
    case (cur.pit)
      lift_service_pkg::PIT_IDLE: begin
        if (pit_insp_switch) begin
          nxt.pit = lift_service_pkg::PIT_INSIDE;
          nxt.blocked = 1'b1;
          nxt.toggled = 1'b0;
        end
      end
      lift_service_pkg::PIT_INSIDE: begin
        if (!pit_insp_switch && pit_stop_actuated) begin
          nxt.pit = lift_service_pkg::PIT_EXITING;
        end
      end
      lift_service_pkg::PIT_EXITING: begin
        if (pit_insp_switch) begin
          nxt.pit = lift_service_pkg::PIT_INSIDE;
        end else if (!pit_stop_actuated) begin
          nxt.pit = pit_door_closed ? lift_service_pkg::PIT_OUT : lift_service_pkg::PIT_FLASH;
          nxt.tk = 16'h0;
          nxt.blink = 16'h0;
          nxt.phase_on = 1'b1;
        end
      end
      lift_service_pkg::PIT_FLASH, lift_service_pkg::PIT_PRESS: begin
        if (cur.tk >= 16'(lift_service_pkg::FLASH_MAX_TK) || pit_insp_switch || pit_stop_actuated) begin
          nxt.pit = lift_service_pkg::PIT_OUT;
        end else if (cur.pit == lift_service_pkg::PIT_FLASH) begin
          if (reset_call && pit_door_closed) begin
            // a press begun in the on phase never counts
            nxt.pit = cur.phase_on ? lift_service_pkg::PIT_OUT : lift_service_pkg::PIT_PRESS;
            nxt.press = 16'h0;
          end
        end else if (!reset_call) begin
          if (cur.press >= 16'(lift_service_pkg::PRESS_MIN_TK) && reset_ok) begin
            nxt.pit = lift_service_pkg::PIT_IDLE;
            nxt.blocked = 1'b0;
          end else begin
            nxt.pit = lift_service_pkg::PIT_OUT;
          end
        end else if (tick) begin
          nxt.press = cur.press + 16'h1;
          if (cur.press >= 16'(lift_service_pkg::PRESS_MAX_TK)) begin
            nxt.pit = lift_service_pkg::PIT_OUT;
          end
        end
      end
      default: begin
        // sequence may be restarted from the pit at any time
        if (pit_stop_actuated) begin
          nxt.pit = lift_service_pkg::PIT_EXITING;
        end
      end
    endcase
    if (cur.pit != lift_service_pkg::PIT_IDLE && reset_ok &&
        (pit_key_reset || unlock_confirmed || (cur.toggled && !service))) begin
      nxt.pit = lift_service_pkg::PIT_IDLE;
      nxt.blocked = 1'b0;
    end
    nxt.lock = (nxt.pit == lift_service_pkg::PIT_IDLE);
    // drive handshake
    case (cur.drv)
      lift_service_pkg::DRV_IDLE: begin
        if (travel_request && chain_ok && (normal_mode || (service && held))) begin
          nxt.drv = lift_service_pkg::DRV_START;
          nxt.drel = 1'b1;
        end
      end
      lift_service_pkg::DRV_START: begin
        nxt.drv = lift_service_pkg::DRV_RUN;
        nxt.up = service ? insp_up : travel_up;
        nxt.down = service ? insp_down : ~travel_up;
        nxt.fast = ~service;
      end
      lift_service_pkg::DRV_RUN: begin
        if (travel_stop || (service && !held)) begin
          nxt.fast = 1'b0;
          nxt.drv = lift_service_pkg::DRV_STOPPING;
        end
      end
      lift_service_pkg::DRV_STOPPING: begin
        if (standstill && !brake_open_signal) begin
          nxt.up = 1'b0;
          nxt.down = 1'b0;
          nxt.hold = 16'h0;
          nxt.drv = lift_service_pkg::DRV_HOLD;
        end
      end
      default: begin
        if (tick && cur.hold >= 16'(lift_service_pkg::RELEASE_DELAY_TK)) begin
          nxt.drel = 1'b0;
          nxt.drv = lift_service_pkg::DRV_IDLE;
        end
      end
    endcase
    // immediate stop on fault, an open safety contact, or both service switches on
    // switch inputs used directly so no start slips through on the edge they meet
    if (inverter_fault || (cur.drv != lift_service_pkg::DRV_IDLE && !chain_ok) ||
        (insp_switch && ero_switch)) begin
      nxt.drv = lift_service_pkg::DRV_IDLE;
      nxt.drel = 1'b0;
      nxt.up = 1'b0;
      nxt.down = 1'b0;
      nxt.fast = 1'b0;
    end
    if (!rst_b) begin
      nxt = '0;
      nxt.pit = lift_service_pkg::PIT_IDLE;
      nxt.drv = lift_service_pkg::DRV_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    cur <= nxt;
  end

  assign normal_mode = ~service & ~cur.blocked;
  assign calls = cur.calls;
  assign correction_travel = cur.need_corr & ~service;
  assign ack_lamp = (cur.pit == lift_service_pkg::PIT_FLASH) & cur.phase_on;
  assign door_lock = cur.lock;
  assign drive_release = cur.drel;
  assign main_contactor = cur.drel;
  assign dir_up = cur.up;
  assign dir_down = cur.down;
  assign fast_speed_command = cur.fast;
  // combinational follow, no added delay; fault gates brake and motor at once
  assign brake_relay = brake_open_signal & ~inverter_fault;
  assign motor_contactor = contactor_relay & ~inverter_fault;
  assign mains_contactor = inverter_mains_on;

  // fault gates the brake and motor relays in the same cycle
  AST_FAULT_BRAKE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    inverter_fault |-> !brake_relay && !motor_contactor) else $error("fault left brake or contactor on");

  // registered drive outputs drop one edge after the fault
  AST_FAULT_STOP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    inverter_fault |=> !drive_release && !fast_speed_command) else $error("fault did not stop drive");

  // mains contactor is a plain wire, never a register
  AST_MAINS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mains_contactor == inverter_mains_on) else $error("mains contactor not following");

  // call registration wiped one edge after car-top inspection
  AST_INSP_CALLS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    insp_switch |=> calls == '0) else $error("calls kept in inspection");

  // second cycle of emergency operation sees no call left
  AST_ERO_CALLS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ero_switch ##1 ero_switch |-> calls == '0) else $error("calls kept in emergency operation");

  // emergency flag never survives an active inspection switch
  AST_INSP_PRIO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    insp_switch |=> !cur.ero_act) else $error("emergency kept under inspection");

  // pit switch held two cycles always blocks normal service
  AST_NO_NORMAL_PIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pit_insp_switch ##1 pit_insp_switch |-> !normal_mode) else $error("normal with pit switch on");

  // lamp never flashes past the window bound
  AST_ACK_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ack_lamp |-> cur.tk <= 16'(lift_service_pkg::FLASH_MAX_TK)) else $error("flash too long");

  // open chain during car-top travel drops release next edge
  AST_SAFETY_STOP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.insp_act && !safety_chain_ok && drive_release |=> !drive_release) else $error("no stop on open chain");

  // fast speed only ever follows an already raised release
  AST_FAST_AFTER_REL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(fast_speed_command) |-> $past(drive_release)) else $error("fast speed before release");

  // start order: release alone first, direction and speed one edge later
  sequence seq_release_only;
    drive_release && !dir_up && !dir_down && !fast_speed_command;
  endsequence
  sequence seq_dir_fast;
    (dir_up ^ dir_down) && fast_speed_command;
  endsequence
  AST_START_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.drv == lift_service_pkg::DRV_START && !service && !inverter_fault && chain_ok &&
      !(insp_switch && ero_switch) |-> seq_release_only ##1 seq_dir_fast)
    else $error("start order broken");

  // pit exit: a press held long enough and let go releases the lift
  sequence seq_press_done;
    cur.pit == lift_service_pkg::PIT_PRESS && !reset_call && reset_ok &&
      cur.press >= 16'(lift_service_pkg::PRESS_MIN_TK) && cur.tk < 16'(lift_service_pkg::FLASH_MAX_TK);
  endsequence
  AST_PRESS_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seq_press_done |=> !cur.blocked && door_lock) else $error("valid press not released");

  // a press let go too early keeps the lift out
  AST_SHORT_PRESS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.pit == lift_service_pkg::PIT_PRESS && !reset_call && cur.press < 16'(lift_service_pkg::PRESS_MIN_TK) &&
      !pit_key_reset && !unlock_confirmed && !cur.toggled |=> cur.blocked) else $error("short press accepted");

  // press begun while the lamp is lit never starts timing
  AST_ON_PHASE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.pit == lift_service_pkg::PIT_FLASH && cur.phase_on && reset_call |=>
      cur.pit != lift_service_pkg::PIT_PRESS) else $error("on phase press timed");

  // group installations never time a landing call press
  AST_GROUP_REFUSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.pit == lift_service_pkg::PIT_FLASH && group_install |=> cur.pit != lift_service_pkg::PIT_PRESS)
    else $error("group accepted landing call reset");

  // key switch releases once the exit conditions hold
  AST_KEY_RESET: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.pit != lift_service_pkg::PIT_IDLE && reset_ok && pit_key_reset |=> !cur.blocked)
    else $error("key reset ignored");

  // open pit door keeps the block in place whatever the reset source
  AST_PIT_DOOR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.blocked && !pit_door_closed |=> cur.blocked) else $error("released with pit door open");

  // emergency travel starts with bypassed contacts open
  AST_ERO_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.ero_act && safety_chain_ok && !bypassed_contacts_ok && travel_request && held && !insp_switch &&
      !inverter_fault && cur.drv == lift_service_pkg::DRV_IDLE |=> drive_release) else $error("bypass not applied");

  // letting go of the inspection button ends the run
  AST_INSP_HELD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.insp_act && !held && cur.drv == lift_service_pkg::DRV_RUN |=>
      cur.drv != lift_service_pkg::DRV_RUN) else $error("run kept without button");

  // both service switches on: no release at all
  AST_BOTH_MODES: assert property (@(posedge ref_clk) disable iff (!rst_b)
    insp_switch && ero_switch |=> !drive_release) else $error("movement with both modes on");

  // release still held with directions gone during the drop delay
  AST_HOLD_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cur.drv == lift_service_pkg::DRV_HOLD |-> drive_release && !dir_up && !dir_down)
    else $error("release dropped before delay");
endmodule // lift_service_mode

/* File: dv/lift_drive_model.sv */
module lift_drive_model (
  input wire logic ref_clk,
  input wire logic drive_release,
  input wire logic dir_up,
  input wire logic dir_down,
  input wire logic fast_speed_command,
  input wire logic fault_cmd,
  output logic brake_open_signal,
  output logic contactor_relay,
  output logic inverter_fault,
  output logic inverter_mains_on,
  output logic standstill
);
  timeunit 1ns;
  timeprecision 1ps;
  int start_cnt = 0;
  int stop_cnt = 0;
  initial begin
    brake_open_signal = 1'b0;
    contactor_relay = 1'b0;
    inverter_fault = 1'b0;
    inverter_mains_on = 1'b1;
    standstill = 1'b1;
  end
  // zero speed until the brake is asked open; brake stays asked open on a fault
  always @(posedge ref_clk) begin
    contactor_relay <= drive_release;
    inverter_fault <= fault_cmd;
    inverter_mains_on <= !fault_cmd;
    if (drive_release && fast_speed_command && (dir_up || dir_down)) begin
      stop_cnt <= 0;
      if (start_cnt == 3) begin
        brake_open_signal <= 1'b1;
        standstill <= 1'b0;
      end else start_cnt <= start_cnt + 1;
    end else begin
      start_cnt <= 0;
      if (stop_cnt == 5) begin
        standstill <= 1'b1;
        brake_open_signal <= 1'b0;
      end else stop_cnt <= stop_cnt + 1;
    end
  end
endmodule // lift_drive_model

/* File: dv/lift_service_mode_tb_top.sv */
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module lift_service_mode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] SEQ [9] = '{3'h0, 3'h2, 3'h6, 3'h7, 3'h5, 3'h7, 3'h6, 3'h2, 3'h0};
  logic ref_clk = 0, rst_b = 0, ero_switch = 0, insp_switch = 0, safety_chain_ok = 1, group_install = 0;
  logic pit_insp_switch = 0, pit_stop_actuated = 0, pit_door_closed = 1, pit_key_reset = 0, fault_cmd = 0;
  logic travel_request = 0, travel_up = 1, travel_stop = 0, insp_up = 0, insp_down = 0, bypassed_contacts_ok = 1;
  logic [lift_service_pkg::N_ACCESS-1:0] lowest_call = 2'h0, reset_access_sel = 2'h1;
  logic [lift_service_pkg::N_CALLS-1:0] call_in = 16'h0, calls;
  logic normal_mode, correction_travel, ack_lamp, door_lock, drive_release, main_contactor, dir_up, dir_down;
  logic fast_speed_command, brake_relay, motor_contactor, mains_contactor;
  logic brake_open_signal, contactor_relay, inverter_fault, inverter_mains_on, standstill;
  int err_count = 0, checks_done = 0, cycles = 0;
  lift_service_mode #(.TICK_CYC(1)) u_dut (
    .ref_clk, .rst_b, .ero_switch, .insp_switch, .insp_up, .insp_down, .safety_chain_ok,
    .bypassed_contacts_ok, .has_abs_encoder(1'b0), .group_install, .pit_insp_switch, .pit_stop_actuated,
    .pit_door_closed, .pit_key_reset, .lowest_call, .reset_access_sel, .unlock_confirmed(1'b0), .call_in,
    .travel_request, .travel_up, .travel_stop, .brake_open_signal, .contactor_relay, .inverter_fault,
    .inverter_mains_on, .standstill, .calls, .normal_mode, .correction_travel, .ack_lamp, .door_lock,
    .drive_release, .main_contactor, .dir_up, .dir_down, .fast_speed_command, .brake_relay, .motor_contactor,
    .mains_contactor);
  lift_drive_model u_drive (.ref_clk, .drive_release, .dir_up, .dir_down, .fast_speed_command, .fault_cmd,
    .brake_open_signal, .contactor_relay, .inverter_fault, .inverter_mains_on, .standstill);
  initial forever #2.5 ref_clk = ~ref_clk;
  // hang guard, sized well above the longest pit sequences
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      finish_test();
    end
  end
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task finish_test;
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one trip; a fault run aborts mid-travel instead of the delayed release drop
  task drive_trip(input logic up, input logic flt);
    int n;
    travel_up = up;
    travel_request = 1'b1;
    cyc(1);
    `CHK({drive_release, main_contactor, fast_speed_command}, 3'h6)
    cyc(1);
    `CHK({dir_up, dir_down, fast_speed_command}, {up, !up, 1'b1})
    n = 0;
    while (brake_open_signal !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    `CHK({brake_relay, motor_contactor, mains_contactor}, 3'h7)
    if (flt) begin
      fault_cmd = 1'b1;
      cyc(1);
      `CHK({brake_open_signal, brake_relay, motor_contactor}, 3'h4)
      `CHK(mains_contactor, 1'b0)
      fault_cmd = 1'b0;
    end
    travel_request = 1'b0;
    travel_stop = 1'b1;
    cyc(1);
    `CHK(fast_speed_command, 1'b0)
    n = 0;
    while (standstill !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    cyc(2);
    `CHK({dir_up, dir_down}, 2'h0)
    if (!flt) begin
      cyc(lift_service_pkg::RELEASE_DELAY_TK - 50);
      `CHK(drive_release, 1'b1)
    end
    cyc(100);
    `CHK(drive_release, 1'b0)
    travel_stop = 1'b0;
  endtask
  // calls are wiped by emergency operation; both modes on together give no release
  task service_modes;
    call_in = 16'h0018;
    cyc(2);
    `CHK(calls, 16'h0018)
    ero_switch = 1'b1;
    cyc(2);
    `CHK(calls, 16'h0)
    call_in = 16'h0001;
    insp_switch = 1'b1;
    insp_up = 1'b1;
    travel_request = 1'b1;
    cyc(4);
    `CHK({calls, normal_mode, drive_release}, 18'h0)
    ero_switch = 1'b0;
    cyc(3);
    `CHK({drive_release, dir_up, dir_down, fast_speed_command}, 4'hC)
    safety_chain_ok = 1'b0;
    cyc(1);
    `CHK(drive_release, 1'b0)
    safety_chain_ok = 1'b1;
    insp_up = 1'b0;
    cyc(2);
    // emergency run with governor and buffer contacts open
    insp_switch = 1'b0;
    ero_switch = 1'b1;
    bypassed_contacts_ok = 1'b0;
    insp_up = 1'b1;
    cyc(3);
    `CHK(drive_release, 1'b1)
    insp_up = 1'b0;
    cyc(510);
    `CHK(drive_release, 1'b0)
    travel_request = 1'b0;
    call_in = 16'h0;
    ero_switch = 1'b0;
    bypassed_contacts_ok = 1'b1;
    cyc(3);
    `CHK({normal_mode, correction_travel}, 2'h3)
  endtask
  // pit in and out in order; a key press is tried while the switch is still on
  task pit_walk;
    for (int i = 0; i < 9; i++) begin
      {pit_door_closed, pit_stop_actuated, pit_insp_switch} = SEQ[i];
      pit_key_reset = (i == 4);
      cyc(3);
      if (i == 4) `CHK(normal_mode, 1'b0)
    end
    pit_key_reset = 1'b0;
  endtask
  task pit_key;
    pit_walk();
    pit_key_reset = 1'b1;
    cyc(3);
    `CHK(normal_mode, 1'b0)
    pit_key_reset = 1'b0;
    pit_door_closed = 1'b1;
    cyc(3);
    pit_key_reset = 1'b1;
    cyc(3);
    pit_key_reset = 1'b0;
    `CHK(normal_mode, 1'b1)
  endtask
  // landing call press begun just after the lamp goes dark
  task pit_call(input int len, input logic grp, input logic [1:0] acc, input logic ok);
    int n;
    group_install = grp;
    pit_walk();
    pit_door_closed = 1'b1;
    n = 0;
    while (ack_lamp !== 1'b1 && n < 1200) begin
      cyc(1);
      n++;
    end
    while (ack_lamp !== 1'b0 && n < 2400) begin
      cyc(1);
      n++;
    end
    lowest_call = acc;
    cyc(len);
    lowest_call = 2'h0;
    cyc(3);
    `CHK({normal_mode, ack_lamp}, {ok, 1'b0})
    group_install = 1'b0;
  endtask
  initial begin
    cyc(3);
    rst_b = 1'b1;
    cyc(2);
    drive_trip(1'b1, 1'b0);
    drive_trip(1'b0, 1'b1);
    service_modes();
    pit_key();
    pit_call(1000, 1'b0, 2'h1, 1'b0);
    pit_call(4000, 1'b1, 2'h1, 1'b0);
    insp_switch = 1'b1;
    cyc(2);
    insp_switch = 1'b0;
    cyc(3);
    `CHK(normal_mode, 1'b1)
    pit_call(4000, 1'b0, 2'h2, 1'b0);
    pit_call(4000, 1'b0, 2'h1, 1'b1);
    `CHK({door_lock, correction_travel}, 2'h3)
    call_in = 16'h0004;
    cyc(2);
    `CHK({calls, correction_travel}, 17'h8)
    finish_test();
  end
endmodule // lift_service_mode_tb_top
